// ---- tpg_pkg.sv ----
// Constants, types and register map of the converter test-pattern generator.
package tpg_pkg;
  localparam logic [14:0] ADR_SOFT = 15'h0000;
  localparam logic [14:0] ADR_DC0 = 15'h0327;
  localparam logic [14:0] ADR_DC1 = 15'h0347;
  localparam logic [14:0] ADR_DC2 = 15'h0367;
  localparam logic [14:0] ADR_DC3 = 15'h0387;
  localparam logic [14:0] ADR_MODE = 15'h0550;
  localparam logic [14:0] ADR_USR0 = 15'h0551;
  localparam logic [14:0] ADR_USR7 = 15'h0558;
  localparam logic [14:0] ADR_LINK = 15'h0573;
  localparam logic [14:0] ADR_LINKX = 15'h0574;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [7:0] SOFT_RST_VAL = 8'h81;
  localparam int SOFT_B0 = 0;
  localparam int SOFT_B7 = 7;
  localparam int MODE_PNRST_L = 4;
  localparam int MODE_PNRST_S = 5;
  localparam int MODE_SINGLE = 7;
  localparam int TEN_BIT = 0;
  localparam int LINK_SEL_LSB = 4;
  localparam logic [3:0] TM_OFF = 4'h0;
  localparam logic [3:0] TM_MID = 4'h1;
  localparam logic [3:0] TM_PFS = 4'h2;
  localparam logic [3:0] TM_NFS = 4'h3;
  localparam logic [3:0] TM_CHK = 4'h4;
  localparam logic [3:0] TM_PNL = 4'h5;
  localparam logic [3:0] TM_PNS = 4'h6;
  localparam logic [3:0] TM_TOG = 4'h7;
  localparam logic [3:0] TM_USR = 4'h8;
  localparam logic [3:0] TM_RAMP = 4'hF;
  localparam logic [13:0] W_ZERO = 14'h0000;
  localparam logic [13:0] W_PFS = 14'h1FFF;
  localparam logic [13:0] W_NFS = 14'h2000;
  localparam logic [13:0] W_CK0 = 14'h1555;
  localparam logic [13:0] W_CK1 = 14'h2AAA;
  localparam logic [13:0] W_ONES = 14'h3FFF;
  // The sequence starts with the seed's lowest bit, but the register shifts left and emits its top
  // bit, so the long seed is held bit-reversed; the nine-bit short seed is its own mirror image.
  localparam logic [22:0] PN_LONG_SEED = 23'h7F_AE00;
  localparam logic [22:0] PN_SHORT_SEED = 23'h00_0092;
  localparam int PNL_MSB = 22;
  localparam int PNL_TAP = 17;
  localparam int PNS_MSB = 8;
  localparam int PNS_TAP = 4;
  localparam logic [2:0] USR_LAST = 3'h3;
  localparam logic [2:0] USR_DONE = 3'h4;
  localparam logic [3:0] INS_LAST = 4'hF;
  localparam logic [3:0] DAT_LAST = 4'h7;
  typedef enum logic {SP_INS, SP_DAT} tpg_spi_st_t;
  typedef struct packed {
    logic [13:0] i;
    logic [13:0] q;
  } tpg_iq_t;
endpackage

// ---- tpg_adc_test_pattern_gen.sv ----
// Converter test-pattern generator with serial control port register file.
// Notes on behaviour
// - Field code 0 passes data, 1 midscale, 2 plus full scale, 3 minus full scale, F a ramp.
// - Code 4 alternates 0x1555 and 0x2AAA every sample.
// - Code 5 runs the long pseudo_random_sequence x^23+x^18+1 from seed 0x3AFF.
// - Code 6 runs the short pseudo_random_sequence x^9+x^5+1 from seed 0x0092.
// - Code 7 alternates all zeros and all ones, zeros first.
// - Code 8 plays user patterns one to four, then repeats or gives zeros in single mode.
// - Any test code replaces converted data with the pattern into output formatting.
// - Bit 4 or bit 5 of the mode register holds both sequence generators at their seeds.
// - A digital_downconverter path carries the pattern only when its enable bit 0 is set.
// - Downconverter paths put the pattern on in-phase data only, never on quadrature.
// - Enable bit 0 of the fourth downconverter routes channel A patterns to its in-phase data.
// - Two link test registers are kept and driven out to the serial-link logic.
// - Writing 0x81 to address 0 soft resets the registers and the value clears itself.
// - Link register bits 3:0 pick the link pattern and bits 5:4 the injection point.
module tpg_adc_test_pattern_gen (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic spiCsN,
  input wire logic spiSclk,
  input wire logic spiSdi,
  output logic spiSdoOut,
  output logic spiSdoOe,
  input wire logic [13:0] adcData,
  input wire tpg_pkg::tpg_iq_t [3:0] ddcIn,
  output tpg_pkg::tpg_iq_t [3:0] ddcOut,
  output logic [13:0] fmtData,
  output logic testActive,
  output logic [3:0] linkPattern,
  output logic [1:0] linkInject,
  output logic [7:0] linkExt
);
  import tpg_pkg::*;

  logic [2:0] csS_r, ckS_r, diS_r;
  logic csF_r, ckF_r, diF_r, ckD_r;
  logic rise, fall;
  tpg_spi_st_t st_r;
  logic [3:0] cnt_r;
  logic [15:0] sh_r;
  logic [14:0] adr_r, wrAdr_r, rdAdr, usrOff;
  logic rd_r, wrStb_r, sdo_r, sdoOe_r;
  logic [7:0] wrDat_r, rdSh_r, rdVal;
  logic [7:0] ctl_r, mode_r, link_r, linkX_r;
  logic [7:0] dcEn_r [4];
  logic [7:0] usr_r [8];
  logic softGo;
  logic [3:0] code, codeD_r;
  logic restart, pnRst, phase, phase_r;
  logic [13:0] ramp, ramp_r, pat, usrWord;
  logic [2:0] idx, idx_r;
  logic [22:0] pnL, pnL_r, pnS, pnS_r;
  logic [36:0] pnLRun, pnSRun;
  logic [13:0] fmt_r;
  logic act_r;
  tpg_iq_t [3:0] ddc_r;

  // Pins are filtered so a single-cycle glitch on the clock pin cannot count as an edge.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      csS_r <= 3'h7;
      ckS_r <= 3'h0;
      diS_r <= 3'h0;
      csF_r <= 1'b1;
      ckF_r <= 1'b0;
      diF_r <= 1'b0;
      ckD_r <= 1'b0;
    end else begin
      csS_r <= {csS_r[1:0], spiCsN};
      ckS_r <= {ckS_r[1:0], spiSclk};
      diS_r <= {diS_r[1:0], spiSdi};
      if (csS_r[2] == csS_r[1]) csF_r <= csS_r[1];
      if (ckS_r[2] == ckS_r[1]) ckF_r <= ckS_r[1];
      if (diS_r[2] == diS_r[1]) diF_r <= diS_r[1];
      ckD_r <= ckF_r;
    end
  end
  assign rise = ckF_r & ~ckD_r;
  assign fall = ckD_r & ~ckF_r;

  // Sixteen instruction bits (read flag, address), then data bytes at rising address.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= SP_INS;
      cnt_r <= 4'h0;
      sh_r <= 16'h0000;
      adr_r <= 15'h0000;
      rd_r <= 1'b0;
      wrStb_r <= 1'b0;
      wrAdr_r <= 15'h0000;
      wrDat_r <= 8'h00;
    end else begin
      wrStb_r <= 1'b0;
      if (csF_r) begin
        st_r <= SP_INS;
        cnt_r <= 4'h0;
      end else if (rise) begin
        sh_r <= {sh_r[14:0], diF_r};
        cnt_r <= cnt_r + 4'h1;
        case (st_r)
          SP_INS: begin
            if (cnt_r == INS_LAST) begin
              rd_r <= sh_r[14];
              adr_r <= {sh_r[13:0], diF_r};
              st_r <= SP_DAT;
              cnt_r <= 4'h0;
            end
          end
          SP_DAT: begin
            if (cnt_r == DAT_LAST) begin
              wrStb_r <= ~rd_r;
              wrAdr_r <= adr_r;
              wrDat_r <= {sh_r[6:0], diF_r};
              adr_r <= adr_r + 15'h0001;
              cnt_r <= 4'h0;
            end
          end
          default: st_r <= SP_INS;
        endcase
      end
    end
  end

  assign rdAdr = (st_r == SP_INS) ? {sh_r[13:0], diF_r} : adr_r + 15'h0001;
  assign usrOff = rdAdr - ADR_USR0;
  always_comb begin
    rdVal = 8'h00;
    case (rdAdr)
      ADR_SOFT: rdVal = ctl_r;
      ADR_DC0: rdVal = dcEn_r[0];
      ADR_DC1: rdVal = dcEn_r[1];
      ADR_DC2: rdVal = dcEn_r[2];
      ADR_DC3: rdVal = dcEn_r[3];
      ADR_MODE: rdVal = mode_r;
      ADR_LINK: rdVal = link_r;
      ADR_LINKX: rdVal = linkX_r;
      default: if (rdAdr >= ADR_USR0 && rdAdr <= ADR_USR7) rdVal = usr_r[usrOff[2:0]];
    endcase
  end

  // Read data leaves on falling edges so the host samples it on the following rise.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rdSh_r <= 8'h00;
      sdo_r <= 1'b0;
      sdoOe_r <= 1'b0;
    end else begin
      sdoOe_r <= ~csF_r && st_r == SP_DAT && rd_r;
      if (!csF_r && rise && (cnt_r == INS_LAST || (st_r == SP_DAT && cnt_r == DAT_LAST))) begin
        rdSh_r <= rdVal;
      end else if (!csF_r && fall && st_r == SP_DAT) begin
        sdo_r <= rdSh_r[7];
        rdSh_r <= {rdSh_r[6:0], 1'b0};
      end
    end
  end

  assign softGo = ctl_r[SOFT_B7] & ctl_r[SOFT_B0];
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ctl_r <= REG_RST;
      mode_r <= REG_RST;
      link_r <= REG_RST;
      linkX_r <= REG_RST;
      for (int k = 0; k < 4; k++) dcEn_r[k] <= REG_RST;
      for (int k = 0; k < 8; k++) usr_r[k] <= REG_RST;
    end else if (softGo) begin
      ctl_r <= REG_RST;
      mode_r <= REG_RST;
      link_r <= REG_RST;
      linkX_r <= REG_RST;
      for (int k = 0; k < 4; k++) dcEn_r[k] <= REG_RST;
      for (int k = 0; k < 8; k++) usr_r[k] <= REG_RST;
    end else if (wrStb_r) begin
      case (wrAdr_r)
        ADR_SOFT: ctl_r <= wrDat_r;
        ADR_DC0: dcEn_r[0] <= wrDat_r;
        ADR_DC1: dcEn_r[1] <= wrDat_r;
        ADR_DC2: dcEn_r[2] <= wrDat_r;
        ADR_DC3: dcEn_r[3] <= wrDat_r;
        ADR_MODE: mode_r <= wrDat_r;
        ADR_LINK: link_r <= wrDat_r;
        ADR_LINKX: linkX_r <= wrDat_r;
        default: begin
          if (wrAdr_r >= ADR_USR0 && wrAdr_r <= ADR_USR7) begin
            usr_r[3'(wrAdr_r - ADR_USR0)] <= wrDat_r;
          end
        end
      endcase
    end
  end

  function automatic logic [36:0] pnRun(input logic [22:0] s, input int msb, input int tap);
    logic [22:0] v;
    logic [13:0] o;
    v = s;
    o = 14'h0000;
    for (int b = 0; b < 14; b++) begin
      o = {o[12:0], v[msb]};
      v = {v[21:0], v[msb] ^ v[tap]};
    end
    return {v, o};
  endfunction

  assign code = mode_r[3:0];
  assign restart = code != codeD_r;
  assign pnRst = mode_r[MODE_PNRST_L] | mode_r[MODE_PNRST_S];
  assign phase = restart ? 1'b0 : phase_r;
  assign ramp = restart ? W_ZERO : ramp_r;
  assign idx = restart ? 3'h0 : idx_r;
  assign pnL = (pnRst || restart) ? PN_LONG_SEED : pnL_r;
  assign pnS = (pnRst || restart) ? PN_SHORT_SEED : pnS_r;
  assign pnLRun = pnRun(pnL, PNL_MSB, PNL_TAP);
  assign pnSRun = pnRun(pnS, PNS_MSB, PNS_TAP);
  assign usrWord = (idx == USR_DONE) ? W_ZERO : {usr_r[2 * idx + 1], usr_r[2 * idx][7:2]};

  always_comb begin
    case (code)
      TM_MID: pat = W_ZERO;
      TM_PFS: pat = W_PFS;
      TM_NFS: pat = W_NFS;
      TM_CHK: pat = phase ? W_CK1 : W_CK0;
      TM_PNL: pat = pnLRun[13:0];
      TM_PNS: pat = pnSRun[13:0];
      TM_TOG: pat = phase ? W_ONES : W_ZERO;
      TM_USR: pat = usrWord;
      TM_RAMP: pat = ramp;
      default: pat = W_ZERO;
    endcase
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      codeD_r <= TM_OFF;
      phase_r <= 1'b0;
      ramp_r <= W_ZERO;
      idx_r <= 3'h0;
      pnL_r <= PN_LONG_SEED;
      pnS_r <= PN_SHORT_SEED;
    end else begin
      codeD_r <= code;
      phase_r <= ~phase;
      ramp_r <= ramp + 14'h0001;
      pnL_r <= pnLRun[36:14];
      pnS_r <= pnSRun[36:14];
      if (idx == USR_LAST) idx_r <= mode_r[MODE_SINGLE] ? USR_DONE : 3'h0;
      else if (idx == USR_DONE) idx_r <= USR_DONE;
      else idx_r <= idx + 3'h1;
    end
  end

  // The analog path is cut only by the code; the sample input is simply not selected.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      fmt_r <= W_ZERO;
      act_r <= 1'b0;
      ddc_r <= '0;
    end else begin
      act_r <= code != TM_OFF;
      fmt_r <= (code != TM_OFF) ? pat : adcData;
      for (int k = 0; k < 4; k++) begin
        ddc_r[k].i <= (code != TM_OFF && dcEn_r[k][TEN_BIT]) ? pat : ddcIn[k].i;
        ddc_r[k].q <= ddcIn[k].q;
      end
    end
  end

  assign spiSdoOut = sdo_r;
  assign spiSdoOe = sdoOe_r;
  assign fmtData = fmt_r;
  assign testActive = act_r;
  assign ddcOut = ddc_r;
  assign linkPattern = link_r[3:0];
  assign linkInject = link_r[LINK_SEL_LSB+1:LINK_SEL_LSB];
  assign linkExt = linkX_r;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  sequence rampRun;
    code == TM_RAMP ##1 code == TM_RAMP;
  endsequence
  sequence usrSingle;
    (code == TM_USR && restart && mode_r[MODE_SINGLE]) ##1
      (code == TM_USR && mode_r[MODE_SINGLE])[*4];
  endsequence
  pass_through_a: assert property (code == TM_OFF |=> fmt_r == $past(adcData))
    else $error("converted sample not passed");
  full_scale_a: assert property (code == TM_PFS |=> fmt_r == W_PFS && act_r)
    else $error("positive full scale word wrong");
  ramp_step_a: assert property (rampRun |=> fmt_r == 14'($past(fmt_r) + 14'h0001))
    else $error("ramp did not step by one");
  checker_alt_a: assert property (code == TM_CHK && !restart && fmt_r == W_CK0 |=> fmt_r == W_CK1)
    else $error("checkerboard did not alternate");
  toggle_start_a: assert property (code == TM_TOG && restart |=> fmt_r == W_ZERO ##1 fmt_r == W_ONES)
    else $error("toggle did not start with zeros");
  pn_hold_a: assert property (code == TM_PNL && pnRst ##1 code == TM_PNL && pnRst |=> fmt_r == $past(fmt_r))
    else $error("sequence not held at seed");
  user_single_a: assert property (usrSingle |=> fmt_r == W_ZERO)
    else $error("single user mode not zero after four");
  ddc_i_test_a: assert property (code != TM_OFF && dcEn_r[3][TEN_BIT] |=> ddc_r[3].i == fmt_r)
    else $error("in-phase data lacks pattern");
  ddc_q_pass_a: assert property (1'b1 |=> ddc_r[0].q == $past(ddcIn[0].q))
    else $error("quadrature data altered");
  soft_clear_a: assert property (wrStb_r && wrAdr_r == ADR_SOFT && wrDat_r == SOFT_RST_VAL |=> ##1 ctl_r == REG_RST && link_r == REG_RST)
    else $error("soft reset did not self clear");
endmodule

// ---- tpg_spi_host.sv ----
// Serial control port host model that reaches the generator's register file.
module tpg_spi_host (
  input wire logic clk_sys,
  output logic spiCsN,
  output logic spiSclk,
  output logic spiSdi,
  input wire logic spiSdoOut,
  input wire logic spiSdoOe
);
  timeunit 1ns;
  timeprecision 100ps;
  logic sdoLine;
  // The read line has a pull-up, so a released line reads high.
  assign sdoLine = spiSdoOe ? spiSdoOut : 1'b1;
  initial begin
    spiCsN = 1'b1;
    spiSclk = 1'b0;
    spiSdi = 1'b0;
  end
  // Each clock level lasts six system cycles so the device's pin filter settles.
  task automatic half();
    repeat (6) @(posedge clk_sys);
    #1;
  endtask
  // One frame: read flag, 15 address bits, 8 data bits, most significant bit first.
  task automatic xfer(input logic rdFlag, input logic [14:0] adr, input logic [7:0] wd,
                      output logic [7:0] rdv);
    logic [23:0] sh;
    sh = {rdFlag, adr, wd};
    rdv = 8'h00;
    spiCsN = 1'b0;
    for (int k = 23; k >= 0; k--) begin
      spiSdi = sh[k];
      half();
      if (k < 8) begin
        rdv[k] = sdoLine;
      end
      spiSclk = 1'b1;
      half();
      spiSclk = 1'b0;
    end
    half();
    spiCsN = 1'b1;
    repeat (12) @(posedge clk_sys);
    #1;
  endtask
endmodule

// ---- testbench.sv ----
// Self-checking testbench for the converter test-pattern generator.
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import tpg_pkg::*;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic spiCsN, spiSclk, spiSdi, spiSdoOut, spiSdoOe, testActive;
  logic [13:0] adcData = 14'h1234;
  logic [13:0] fmtData, hv;
  tpg_iq_t [3:0] ddcIn, ddcOut;
  logic [3:0] linkPattern;
  logic [1:0] linkInject;
  logic [7:0] linkExt, rv;
  int err_total = 0;
  int checked = 0;
  logic [14:0] adrs[11] = '{ADR_SOFT, ADR_DC0, ADR_DC1, ADR_DC2, ADR_DC3, ADR_MODE, ADR_USR0,
    ADR_USR7, ADR_LINK, ADR_LINKX, 15'h0100};
  logic [7:0] modes[11] = '{8'h01, 8'h02, 8'h03, 8'h06, 8'h07, 8'h0F, 8'h08, 8'h88, 8'h05,
    8'h09, 8'h04};
  logic [13:0] pats[11][5] = '{'{5{14'h0000}}, '{5{14'h1FFF}}, '{5{14'h2000}},
    '{14'h125B, 14'h3C9A, 14'h2660, 14'h0C65, 14'h0697},
    '{14'h0000, 14'h3FFF, 14'h0000, 14'h3FFF, 14'h0000},
    '{14'h0000, 14'h0001, 14'h0002, 14'h0003, 14'h0004},
    '{14'h0884, 14'h110C, 14'h1995, 14'h221D, 14'h0884},
    '{14'h0884, 14'h110C, 14'h1995, 14'h221D, 14'h0000},
    '{14'h3FD7, 14'h0002, 14'h26E0, 14'h0A3D, 14'h1CA6},
    '{5{14'h0000}},
    '{14'h1555, 14'h2AAA, 14'h1555, 14'h2AAA, 14'h1555}};
  logic [7:0] holds[3] = '{8'h15, 8'h25, 8'h16};

  // The encode clock never stops, test patterns included.
  always #2.5 clk_sys = ~clk_sys;

  tpg_adc_test_pattern_gen dut_u (.clk_sys, .reset_n, .spiCsN, .spiSclk, .spiSdi, .spiSdoOut,
    .spiSdoOe, .adcData, .ddcIn, .ddcOut, .fmtData, .testActive, .linkPattern, .linkInject,
    .linkExt);
  tpg_spi_host host_u (.clk_sys, .spiCsN, .spiSclk, .spiSdi, .spiSdoOut, .spiSdoOe);

  task automatic check(input logic [13:0] seen, input logic [13:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    host_u.xfer(1'b0, a, d, rv);
  endtask
  task automatic rd(input logic [14:0] a);
    host_u.xfer(1'b1, a, 8'h00, rv);
  endtask
  task automatic tick();
    @(posedge clk_sys);
    #1;
  endtask
  // The first word differing from the sample input marks the pattern start.
  task automatic runPat(input logic [7:0] mode, input logic [13:0] w[5]);
    int n;
    n = 0;
    wr(ADR_MODE, 8'h00);
    check(fmtData, adcData);
    check(14'(testActive), 14'h0000);
    fork
      wr(ADR_MODE, mode);
      begin
        while (fmtData === adcData && n < 400) begin
          tick();
          n++;
        end
        for (int k = 0; k < 5; k++) begin
          check(fmtData, w[k]);
          tick();
        end
      end
    join
    check(14'(testActive), 14'h0001);
  endtask
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    for (int k = 0; k < 4; k++) begin
      ddcIn[k] = {14'h0100 + 14'(k), 14'h0200 + 14'(k)};
    end
    repeat (20) @(posedge clk_sys);
    #1;
    reset_n = 1'b1;
    repeat (6) tick();
    foreach (adrs[j]) begin
      rd(adrs[j]);
      check(14'(rv), 14'h0000);
    end
    $display("Test register reset values done");
    for (int j = 0; j < 8; j++) begin
      wr(ADR_USR0 + 15'(j), 8'(17 * (j + 1)));
    end
    rd(ADR_USR7);
    check(14'(rv), 14'h0088);
    foreach (modes[j]) begin
      runPat(modes[j], pats[j]);
    end
    $display("Test pattern codes done");
    wr(ADR_DC0, 8'h01);
    wr(ADR_DC3, 8'h01);
    check(ddcOut[0].i, fmtData);
    check(ddcOut[3].i, fmtData);
    check(ddcOut[1].i, ddcIn[1].i);
    check(ddcOut[0].q, ddcIn[0].q);
    $display("Test downconverter paths done");
    foreach (holds[j]) begin
      wr(ADR_MODE, holds[j]);
      hv = fmtData;
      repeat (3) begin
        tick();
        check(fmtData, hv);
      end
    end
    wr(ADR_MODE, 8'h05);
    hv = fmtData;
    tick();
    check(14'(fmtData !== hv), 14'h0001);
    $display("Test sequence hold done");
    wr(ADR_LINK, 8'h25);
    wr(ADR_LINKX, 8'hA5);
    check(14'(linkPattern), 14'h0005);
    check(14'(linkInject), 14'h0002);
    check(14'(linkExt), 14'h00A5);
    wr(ADR_SOFT, SOFT_RST_VAL);
    check(14'(linkPattern), 14'h0000);
    check(14'(linkInject), 14'h0000);
    check(14'(linkExt), 14'h0000);
    check(fmtData, adcData);
    rd(ADR_SOFT);
    check(14'(rv), 14'h0000);
    rd(ADR_DC0);
    check(14'(rv), 14'h0000);
    $display("Test link registers and soft reset done");
    conclude();
  end

  // The full sequence needs about 81 us; the limit leaves ample margin.
  initial begin
    #300us;
    err_total++;
    $display("Error at %0t: watchdog expired", $time);
    conclude();
  end
endmodule
